// *** verilog/dlc_cfg.svh ***
// register offsets, field positions, reset values and sizes of the data-link/overhead block
`ifndef DLC_CFG_SVH
`define DLC_CFG_SVH
// ==========================================================
// register offsets
`define DLC_ADDR_RX_DL_STATUS   8'h15
`define DLC_ADDR_TX_OVH_CTRL    8'h16
`define DLC_ADDR_FMASK_MID      8'h19
`define DLC_ADDR_FMASK_LOW_MID  8'h1a
`define DLC_ADDR_FMASK_LOW      8'h1b
`define DLC_ADDR_TX_DL_SETUP    8'h1e
// ==========================================================
// receive data-link status fields
`define DLC_RXS_ABORT           6
`define DLC_RXS_KIND_LSB        4
`define DLC_RXS_ORIGIN          3
`define DLC_RXS_CHECK_FAIL      2
`define DLC_RXS_COMPLETE        1
`define DLC_RXS_FLAG            0
// ==========================================================
// transmit overhead control fields and reset value
`define DLC_TXC_FORCE_X_LOW     7
`define DLC_TXC_FORCE_X_HIGH    6
`define DLC_TXC_SEND_IDLE       5
`define DLC_TXC_SEND_AIS        4
`define DLC_TXC_SEND_ZEROS      3
`define DLC_TXC_FERF_LOS        2
`define DLC_TXC_FERF_OOF        1
`define DLC_TXC_FERF_AIS        0
`define DLC_TXC_RESET           8'h07
// ==========================================================
// transmit data-link setup: bits 7-5 read zero
`define DLC_TXD_WR_MASK         8'h1f
`define DLC_TXD_RESET           8'h08
`define DLC_TXD_AUTO_REPEAT     3
`define DLC_TXD_KIND_LSB        1
`define DLC_TXD_ENABLE          0
`define DLC_FMASK_RESET         24'h00_0000
// ==========================================================
// message buffer depth in 16-bit words by message kind
`define DLC_DEPTH_SHORT_WORDS   6'h26
`define DLC_DEPTH_LONG_WORDS    6'h29
`endif

// *** verilog/dlc_pkg.sv ***
// types shared by the data-link status and transmit overhead block
package dlc_pkg;
  // ========================================================
  // payload pattern chosen for the outgoing frame
  typedef enum logic [1:0] {
    PAT_NORMAL = 2'b00,
    PAT_IDLE   = 2'b01,
    PAT_AIS    = 2'b10,
    PAT_ZEROS  = 2'b11
  } dlc_pat_e;
  // ========================================================
  // receive message tracker states
  typedef enum logic [1:0] {
    RXM_EMPTY = 2'b00,
    RXM_BUSY  = 2'b01,
    RXM_HELD  = 2'b10
  } dlc_rxm_e;
  // ========================================================
  // attributes of a received data-link message
  typedef struct packed {
    logic [1:0] kind;
    logic       origin;
    logic       check_fail;
  } dlc_rx_msg_s;
  // overhead applied to one whole outgoing frame
  typedef struct packed {
    dlc_pat_e   pattern;
    logic       x_value;
  } dlc_tx_frame_s;
endpackage

// *** verilog/dlc_sync3.sv ***
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module dlc_sync3 #(
  parameter int        WIDTH = 1,
  parameter bit [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q     <= INIT[WIDTH-1:0];
      s2_q     <= INIT[WIDTH-1:0];
      s3_q     <= INIT[WIDTH-1:0];
      sync_out <= INIT[WIDTH-1:0];
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit: a disagreeing bit keeps its old value
      sync_out <= (s2_q & ~(s2_q ^ s3_q)) | (sync_out & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire

// *** verilog/dlc_tx_ovh.sv ***
// transmit overhead selection: pattern priority, x-bit value, frame-aligned update
`timescale 1ns/10ps
`default_nettype none
`include "dlc_cfg.svh"
module dlc_tx_ovh (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            ovh_ctrl,
  input  wire logic                  rx_los,
  input  wire logic                  rx_oof,
  input  wire logic                  rx_ais,
  input  wire logic                  tx_mframe_start,
  output dlc_pkg::dlc_tx_frame_s     frame_q
);
  dlc_pkg::dlc_tx_frame_s frame_d;
  logic                   remote_fail;
  // ========================================================
  // defect-driven far-end failure indication
  always_comb begin
    remote_fail = (ovh_ctrl[`DLC_TXC_FERF_LOS] & rx_los)
                | (ovh_ctrl[`DLC_TXC_FERF_OOF] & rx_oof)
                | (ovh_ctrl[`DLC_TXC_FERF_AIS] & rx_ais);
  end
  // ========================================================
  // fixed priority, highest first
  always_comb begin
    frame_d.pattern = dlc_pkg::PAT_NORMAL;
    frame_d.x_value = ~remote_fail;
    if (ovh_ctrl[`DLC_TXC_SEND_ZEROS]) begin
      frame_d.pattern = dlc_pkg::PAT_ZEROS;
    end else if (ovh_ctrl[`DLC_TXC_SEND_AIS]) begin
      frame_d.pattern = dlc_pkg::PAT_AIS;
    end else if (ovh_ctrl[`DLC_TXC_SEND_IDLE]) begin
      frame_d.pattern = dlc_pkg::PAT_IDLE;
    end else if (ovh_ctrl[`DLC_TXC_FORCE_X_LOW]) begin
      frame_d.x_value = 1'b0;
    end else if (ovh_ctrl[`DLC_TXC_FORCE_X_HIGH]) begin
      frame_d.x_value = 1'b1;
    end
  end
  // ========================================================
  // held for the whole frame so no frame mixes overhead settings
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frame_q <= '{pattern: dlc_pkg::PAT_NORMAL, x_value: 1'b1};
    end else if (tx_mframe_start) begin
      frame_q <= frame_d;
    end
  end
endmodule
`default_nettype wire

// *** verilog/dlc_top.sv ***
// data-link receive status and transmit overhead control register bank
//
// Overview of operation
// - abort status bit 6 is high while an abort sequence is being received
// - message kind: 00 test, 01 idle, 10 path, 11 international path identification; status bits 5-4 show the kind with its two bits swapped
// - buffer depth is 38 words for kinds 00-10 and 41 words for 11
// - origin bit 3: 0 customer installation, 1 network terminal
// - check-fail bit 2 reports CRC-16 failure of the latest message
// - complete bit 1 is high while a whole message sits in the buffer
// - flag bit 0 is high while the flag sequence is being received
// - receive status bits carry meaning only in C-bit parity framing
// - force-x-low control sets all outgoing X-bits to 0
// - force-x-high control sets all outgoing X-bits to 1
// - with no forcing, X-bits follow receive framer defect conditions
// - send-idle control inserts the idle pattern
// - send-alarm-indication control inserts the AIS pattern
// - send-all-zeros control sends an all-zeros pattern
// - priority: zeros, AIS, idle, then the X-bit forcing controls
// - far-end failure sent on loss of signal when enabled, default on
// - far-end failure sent on out-of-frame when enabled, default on
// - far-end failure sent on incoming AIS when enabled, default on
// - each of F-bits 0-23 is XORed with its mask bit, bit 0 first F-bit
// - mask bits 23-16 at 0x19, 15-8 at 0x1a, 7-0 at 0x1b
`timescale 1ns/10ps
`default_nettype none
`include "dlc_cfg.svh"
module dlc_top (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // microprocessor pins, asynchronous to ref_clk
  input  wire logic                   up_cs_n,
  input  wire logic                   up_rd_n,
  input  wire logic                   up_wr_n,
  input  wire logic [7:0]             up_addr,
  input  wire logic [7:0]             up_data_in,
  output logic      [7:0]             up_data_out,
  output logic                        up_data_oe_n,
  // framing format, from the framer configuration
  input  wire logic                   cbit_mode,
  // receive message engine, same clock
  input  wire logic                   rx_abort_seen,
  input  wire logic                   rx_flag_seen,
  input  wire logic                   rx_msg_start,
  input  wire logic                   rx_msg_end,
  input  wire dlc_pkg::dlc_rx_msg_s   rx_msg_info,
  input  wire logic                   rx_buffer_drained,
  output logic      [5:0]             rx_buffer_words,
  // receive framer defects, same clock
  input  wire logic                   rx_los,
  input  wire logic                   rx_oof,
  input  wire logic                   rx_ais,
  // transmit framer timing and F-bit path, same clock
  input  wire logic                   tx_mframe_start,
  input  wire logic                   tx_fbit_strobe,
  input  wire logic [4:0]             tx_fbit_index,
  input  wire logic                   tx_fbit_in,
  output logic                        tx_fbit_out,
  output logic                        tx_fbit_out_valid,
  output dlc_pkg::dlc_tx_frame_s      tx_frame_ctrl,
  // transmit data-link setup fields
  output logic                        tx_dl_enable,
  output logic      [1:0]             tx_dl_kind,
  output logic                        tx_dl_auto_repeat
);
  // ========================================================
  // pin synchronisers
  logic [2:0]             strobes_n;
  logic [7:0]             addr_s;
  logic [7:0]             wdata_s;
  logic                   wr_act;
  logic                   rd_act;
  logic                   wr_act_q;
  logic                   wr_pulse;

  // strobes idle high, so they reset to ones
  dlc_sync3 #(
    .WIDTH (3),
    .INIT  (32'h0000_0007)
  ) u_sync_strobe (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in ({up_cs_n, up_rd_n, up_wr_n}),
    .sync_out (strobes_n)
  );

  dlc_sync3 #(
    .WIDTH (8),
    .INIT  (32'h0000_0000)
  ) u_sync_addr (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (up_addr),
    .sync_out (addr_s)
  );

  dlc_sync3 #(
    .WIDTH (8),
    .INIT  (32'h0000_0000)
  ) u_sync_wdata (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (up_data_in),
    .sync_out (wdata_s)
  );

  assign wr_act = ~strobes_n[2] & ~strobes_n[0];
  assign rd_act = ~strobes_n[2] & ~strobes_n[1];

  // a write lands once, on the start of the strobe; address and data
  // went through the same depth of synchroniser so they line up with it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
    end
  end

  assign wr_pulse = wr_act & ~wr_act_q;

  // ========================================================
  // software-written registers
  logic [7:0]             ovh_ctrl_q;
  logic [23:0]            fmask_q;
  logic [7:0]             dl_setup_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ovh_ctrl_q <= `DLC_TXC_RESET;
    end else if (wr_pulse && addr_s == `DLC_ADDR_TX_OVH_CTRL) begin
      ovh_ctrl_q <= wdata_s;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fmask_q <= `DLC_FMASK_RESET;
    end else if (wr_pulse) begin
      case (addr_s)
        `DLC_ADDR_FMASK_MID: begin
          fmask_q[23:16] <= wdata_s;
        end
        `DLC_ADDR_FMASK_LOW_MID: begin
          fmask_q[15:8] <= wdata_s;
        end
        `DLC_ADDR_FMASK_LOW: begin
          fmask_q[7:0] <= wdata_s;
        end
        default: begin
          fmask_q <= fmask_q;
        end
      endcase
    end
  end

  // upper three bits are unused and stay zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dl_setup_q <= `DLC_TXD_RESET;
    end else if (wr_pulse && addr_s == `DLC_ADDR_TX_DL_SETUP) begin
      dl_setup_q <= wdata_s & `DLC_TXD_WR_MASK;
    end
  end

  assign tx_dl_enable      = dl_setup_q[`DLC_TXD_ENABLE];
  assign tx_dl_kind        = dl_setup_q[`DLC_TXD_KIND_LSB +: 2];
  assign tx_dl_auto_repeat = dl_setup_q[`DLC_TXD_AUTO_REPEAT];

  // ========================================================
  // receive message tracker
  dlc_pkg::dlc_rxm_e      rxm_q;
  dlc_pkg::dlc_rxm_e      rxm_d;
  dlc_pkg::dlc_rx_msg_s   msg_q;
  logic                   abort_q;
  logic                   flag_q;

  // end of message beats a drain or a new start in the same cycle,
  // so a completed message is never lost to a racing clear
  always_comb begin
    rxm_d = rxm_q;
    case (rxm_q)
      dlc_pkg::RXM_EMPTY: begin
        if (rx_msg_end) begin
          rxm_d = dlc_pkg::RXM_HELD;
        end else if (rx_msg_start) begin
          rxm_d = dlc_pkg::RXM_BUSY;
        end
      end
      dlc_pkg::RXM_BUSY: begin
        if (rx_msg_end) begin
          rxm_d = dlc_pkg::RXM_HELD;
        end else if (rx_buffer_drained) begin
          rxm_d = dlc_pkg::RXM_EMPTY;
        end
      end
      dlc_pkg::RXM_HELD: begin
        if (rx_msg_end) begin
          rxm_d = dlc_pkg::RXM_HELD;
        end else if (rx_msg_start) begin
          rxm_d = dlc_pkg::RXM_BUSY;
        end else if (rx_buffer_drained) begin
          rxm_d = dlc_pkg::RXM_EMPTY;
        end
      end
      default: begin
        rxm_d = dlc_pkg::RXM_EMPTY;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxm_q <= dlc_pkg::RXM_EMPTY;
    end else begin
      rxm_q <= rxm_d;
    end
  end

  // attributes belong to the most recently completed message
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      msg_q <= '0;
    end else if (rx_msg_end) begin
      msg_q <= rx_msg_info;
    end
  end

  // live conditions, registered once for a clean read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      abort_q <= 1'b0;
      flag_q  <= 1'b0;
    end else begin
      abort_q <= rx_abort_seen;
      flag_q  <= rx_flag_seen;
    end
  end

  // buffer depth tracks the held message kind
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_buffer_words <= `DLC_DEPTH_SHORT_WORDS;
    end else if (msg_q.kind == 2'b11) begin
      rx_buffer_words <= `DLC_DEPTH_LONG_WORDS;
    end else begin
      rx_buffer_words <= `DLC_DEPTH_SHORT_WORDS;
    end
  end

  // ========================================================
  // receive status image; outside C-bit parity it reads zero
  logic [7:0]             rx_status;

  always_comb begin
    rx_status                               = 8'h00;
    rx_status[`DLC_RXS_ABORT]               = abort_q;
    rx_status[`DLC_RXS_KIND_LSB +: 2]       = {msg_q.kind[0], msg_q.kind[1]};
    rx_status[`DLC_RXS_ORIGIN]              = msg_q.origin;
    rx_status[`DLC_RXS_CHECK_FAIL]          = msg_q.check_fail;
    rx_status[`DLC_RXS_COMPLETE]            = (rxm_q == dlc_pkg::RXM_HELD);
    rx_status[`DLC_RXS_FLAG]                = flag_q;
    if (!cbit_mode) begin
      rx_status = 8'h00;
    end
  end

  // ========================================================
  // read path; unmapped addresses read zero
  logic [7:0]             rdata_d;

  always_comb begin
    case (addr_s)
      `DLC_ADDR_RX_DL_STATUS: begin
        rdata_d = rx_status;
      end
      `DLC_ADDR_TX_OVH_CTRL: begin
        rdata_d = ovh_ctrl_q;
      end
      `DLC_ADDR_FMASK_MID: begin
        rdata_d = fmask_q[23:16];
      end
      `DLC_ADDR_FMASK_LOW_MID: begin
        rdata_d = fmask_q[15:8];
      end
      `DLC_ADDR_FMASK_LOW: begin
        rdata_d = fmask_q[7:0];
      end
      `DLC_ADDR_TX_DL_SETUP: begin
        rdata_d = dl_setup_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // data refreshed every cycle of the read so live bits stay current
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      up_data_out <= 8'h00;
    end else if (rd_act) begin
      up_data_out <= rdata_d;
    end
  end

  // drive the bus only while a read strobe is seen
  assign up_data_oe_n = ~rd_act;

  // ========================================================
  // transmit overhead for each frame
  dlc_tx_ovh u_tx_ovh (
    .ref_clk         (ref_clk),
    .nrst            (nrst),
    .ovh_ctrl        (ovh_ctrl_q),
    .rx_los          (rx_los),
    .rx_oof          (rx_oof),
    .rx_ais          (rx_ais),
    .tx_mframe_start (tx_mframe_start),
    .frame_q         (tx_frame_ctrl)
  );

  // ========================================================
  // F-bit error injection; mask positions 24-27 have no register
  // here and pass their F-bits unchanged
  logic                   mask_bit;

  always_comb begin
    mask_bit = 1'b0;
    if (tx_fbit_index < 5'd24) begin
      mask_bit = fmask_q[tx_fbit_index];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_fbit_out       <= 1'b0;
      tx_fbit_out_valid <= 1'b0;
    end else begin
      tx_fbit_out_valid <= tx_fbit_strobe;
      if (tx_fbit_strobe) begin
        tx_fbit_out <= tx_fbit_in ^ mask_bit;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/dlc_top_asserts.sv ***
// concurrent checks on the ports of the data-link status and overhead block
`timescale 1ns/10ps
`default_nettype none
`include "dlc_cfg.svh"
module dlc_top_chk (
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  input wire logic                   up_cs_n,
  input wire logic                   up_rd_n,
  input wire logic [7:0]             up_data_out,
  input wire logic                   up_data_oe_n,
  input wire logic                   rx_msg_end,
  input wire dlc_pkg::dlc_rx_msg_s   rx_msg_info,
  input wire logic [5:0]             rx_buffer_words,
  input wire logic                   tx_mframe_start,
  input wire logic                   tx_fbit_strobe,
  input wire logic [4:0]             tx_fbit_index,
  input wire logic                   tx_fbit_in,
  input wire logic                   tx_fbit_out,
  input wire logic                   tx_fbit_out_valid,
  input wire dlc_pkg::dlc_tx_frame_s tx_frame_ctrl
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================
  // sequences
  sequence s_msg_done;
    rx_msg_end ##1 !rx_msg_end;
  endsequence
  // six idle cycles outlast the pin synchroniser
  sequence s_rd_idle;
    (up_cs_n || up_rd_n) [*6];
  endsequence
  // ==========================================================
  // assertions
  AST_FBIT_PASS: assert property (tx_fbit_strobe && tx_fbit_index >= 5'h18
    |=> tx_fbit_out == $past(tx_fbit_in)) else $error("unmasked F-bit slot altered");
  AST_FBIT_VALID: assert property (tx_fbit_strobe |=> tx_fbit_out_valid)
    else $error("F-bit strobe gave no output pulse");
  AST_FBIT_QUIET: assert property (!tx_fbit_strobe |=> !tx_fbit_out_valid)
    else $error("F-bit output pulse without strobe");
  AST_FRAME_HOLD: assert property (!tx_mframe_start |=> $stable(tx_frame_ctrl))
    else $error("frame overhead changed inside a frame");
  AST_BUF_DEPTH: assert property (s_msg_done |=> rx_buffer_words ==
    (($past(rx_msg_info.kind, 2) == 2'h3) ? `DLC_DEPTH_LONG_WORDS : `DLC_DEPTH_SHORT_WORDS))
    else $error("buffer depth does not follow message kind");
  AST_DEPTH_HOLD: assert property (!rx_msg_end [*2] |=> $stable(rx_buffer_words))
    else $error("buffer depth changed without a message");
  AST_OE_IDLE: assert property (s_rd_idle |-> up_data_oe_n)
    else $error("data bus driven without a read");
  AST_OE_ACTIVE: assert property ((!up_cs_n && !up_rd_n) [*6] |-> !up_data_oe_n)
    else $error("data bus not driven during a read");
  AST_DATA_HOLD: assert property (s_rd_idle |=> $stable(up_data_out))
    else $error("read data changed outside a read");
endmodule
bind dlc_top dlc_top_chk u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .up_cs_n(up_cs_n), .up_rd_n(up_rd_n),
  .up_data_out(up_data_out), .up_data_oe_n(up_data_oe_n), .rx_msg_end(rx_msg_end),
  .rx_msg_info(rx_msg_info), .rx_buffer_words(rx_buffer_words),
  .tx_mframe_start(tx_mframe_start), .tx_fbit_strobe(tx_fbit_strobe),
  .tx_fbit_index(tx_fbit_index), .tx_fbit_in(tx_fbit_in), .tx_fbit_out(tx_fbit_out),
  .tx_fbit_out_valid(tx_fbit_out_valid), .tx_frame_ctrl(tx_frame_ctrl)
);
`default_nettype wire

// *** sim/dlc_line_model.sv ***
// far-side model: transmit framer timing and raw F-bits toward the block
`timescale 1ns/10ps
`default_nettype none
module dlc_line_model #(
  parameter int FRAME_CYCLES = 64
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  output wire logic       mframe_start,
  output wire logic       fbit_strobe,
  output wire logic [4:0] fbit_index,
  output wire logic       fbit_in
);
  int   cyc   = 0;
  int   seed  = 32'h0000_5a17;
  logic bit_q = 1'h0;
  // ==========================================================
  // frame timing: 28 F-bit slots every other cycle, first slot first
  assign mframe_start = nrst && cyc == 0;
  assign fbit_strobe  = nrst && cyc[0] && cyc < 56;
  assign fbit_index   = 5'(cyc >> 1);
  // raw bit redrawn at random every cycle so a stale value seldom looks fresh
  assign fbit_in      = bit_q;
  always @(negedge ref_clk) begin
    cyc   <= (!nrst || cyc == FRAME_CYCLES - 1) ? 0 : cyc + 1;
    bit_q <= 1'($random(seed));
  end
endmodule
`default_nettype wire

// *** sim/dlc_top_tb_top.sv ***
// self-checking bench for the data-link status and transmit overhead block
`timescale 1ns/10ps
`default_nettype none
module dlc_top_tb_top;
  logic                   ref_clk = 1'h0, nrst = 1'h0, cbit_mode = 1'h1;
  logic                   up_cs_n = 1'h1, up_rd_n = 1'h1, up_wr_n = 1'h1;
  logic                   rx_abort_seen = 1'h0, rx_flag_seen = 1'h0, rx_buffer_drained = 1'h0;
  logic                   rx_msg_start = 1'h0, rx_msg_end = 1'h0;
  logic                   rx_los = 1'h0, rx_oof = 1'h0, rx_ais = 1'h0;
  logic [7:0]             up_addr = 8'h00, up_data_in = 8'h00, up_data_out, rd_q, c;
  logic                   up_data_oe_n, tx_fbit_out, tx_fbit_out_valid, mf, fs, fi, fb_on = 1'h0;
  logic                   tx_dl_enable, tx_dl_auto_repeat;
  logic [1:0]             tx_dl_kind;
  logic [2:0]             d;
  logic [3:0]             m;
  logic [4:0]             fx;
  logic [5:0]             rx_buffer_words;
  logic [23:0]            fmask = 24'h00_0000;
  dlc_pkg::dlc_rx_msg_s   rx_msg_info = '0;
  dlc_pkg::dlc_tx_frame_s tx_frame_ctrl, e;
  int                     seed = 32'h0000_38b7, errors = 0, compares = 0, cycles = 0;
  localparam logic [7:0] RA [6] = '{8'h15, 8'h16, 8'h19, 8'h1a, 8'h1b, 8'h1e};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h08};
  localparam logic [7:0] TC [10] = '{8'h08, 8'h18, 8'h30, 8'he0, 8'h20, 8'h80, 8'h40, 8'hc0, 8'h07, 8'h00};

  dlc_top uut (
    .ref_clk(ref_clk), .nrst(nrst), .up_cs_n(up_cs_n), .up_rd_n(up_rd_n), .up_wr_n(up_wr_n),
    .up_addr(up_addr), .up_data_in(up_data_in), .up_data_out(up_data_out),
    .up_data_oe_n(up_data_oe_n), .cbit_mode(cbit_mode), .rx_abort_seen(rx_abort_seen),
    .rx_flag_seen(rx_flag_seen), .rx_msg_start(rx_msg_start), .rx_msg_end(rx_msg_end),
    .rx_msg_info(rx_msg_info), .rx_buffer_drained(rx_buffer_drained),
    .rx_buffer_words(rx_buffer_words), .rx_los(rx_los), .rx_oof(rx_oof), .rx_ais(rx_ais),
    .tx_mframe_start(mf), .tx_fbit_strobe(fs), .tx_fbit_index(fx), .tx_fbit_in(fi),
    .tx_fbit_out(tx_fbit_out), .tx_fbit_out_valid(tx_fbit_out_valid),
    .tx_frame_ctrl(tx_frame_ctrl), .tx_dl_enable(tx_dl_enable), .tx_dl_kind(tx_dl_kind),
    .tx_dl_auto_repeat(tx_dl_auto_repeat)
  );
  dlc_line_model #(.FRAME_CYCLES(64)) u_line (
    .ref_clk(ref_clk), .nrst(nrst), .mframe_start(mf), .fbit_strobe(fs),
    .fbit_index(fx), .fbit_in(fi)
  );

  always #10 ref_clk = ~ref_clk;
  // ==========================================================
  // checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out;
    end
  end
  // ==========================================================
  // expectations
  function automatic dlc_pkg::dlc_tx_frame_s exp_frame(input logic [7:0] k, input logic [2:0] df);
    dlc_pkg::dlc_tx_frame_s f;
    f.pattern = k[3] ? dlc_pkg::PAT_ZEROS : k[4] ? dlc_pkg::PAT_AIS :
                k[5] ? dlc_pkg::PAT_IDLE : dlc_pkg::PAT_NORMAL;
    f.x_value = k[7] ? 1'h0 : k[6] ? 1'h1 : !(|(k[2:0] & df));
    return f;
  endfunction
  function automatic logic [7:0] exp_stat(input logic [3:0] mi, input logic done);
    return {1'h0, rx_abort_seen, mi[2], mi[3], mi[1], mi[0], done, rx_flag_seen};
  endfunction
  // ==========================================================
  // drivers: pins held steady for the whole strobe, wide gap after
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] dat);
    @(negedge ref_clk);
    up_addr = a;
    up_data_in = dat;
    @(negedge ref_clk);
    up_cs_n = 1'h0;
    up_wr_n = !wr;
    up_rd_n = wr;
    repeat (8) @(negedge ref_clk);
    rd_q = up_data_out;
    up_cs_n = 1'h1;
    up_wr_n = 1'h1;
    up_rd_n = 1'h1;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    bus(1'h0, a, 8'h00);
    chk(rd_q, x);
  endtask
  task automatic msg(input logic [3:0] mi, input logic both);
    @(negedge ref_clk) rx_msg_start = 1'h1;
    @(negedge ref_clk) rx_msg_start = 1'h0;
    repeat (3) @(negedge ref_clk);
    rx_msg_end = 1'h1;
    rx_msg_start = both;
    rx_msg_info = mi;
    @(negedge ref_clk);
    rx_msg_end = 1'h0;
    rx_msg_start = 1'h0;
    rx_msg_info = ~mi;
    repeat (2) @(negedge ref_clk);
  endtask
  // F-bit slot sampled at the last rising edge shows its result now
  always @(negedge ref_clk) begin
    if (fb_on && fs) begin
      chk(tx_fbit_out_valid, 8'h01);
      chk(tx_fbit_out, fi ^ ((fx < 5'h18) && fmask[fx]));
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (16) @(negedge ref_clk);
    nrst = 1'h1;
    bus(1'h1, 8'h15, 8'hff);
    bus(1'h1, 8'h40, 8'h5a);
    rdc(8'h40, 8'h00);
    for (int i = 0; i < 6; i++)
      rdc(RA[i], RV[i]);
    chk(rx_buffer_words, 8'h26);
    c = 8'($random(seed));
    bus(1'h1, 8'h1e, c);
    rdc(8'h1e, c & 8'h1f);
    chk({tx_dl_enable, tx_dl_kind, tx_dl_auto_repeat}, {c[0], c[2:1], c[3]});
    for (int k = 0; k < 3; k++) begin
      fmask = (k == 0) ? 24'h80_0001 : 24'($random(seed));
      for (int j = 0; j < 3; j++)
        bus(1'h1, RA[j + 2], fmask[8 * (2 - j) +: 8]);
      for (int j = 0; j < 3; j++)
        rdc(RA[j + 2], fmask[8 * (2 - j) +: 8]);
      fb_on = 1'h1;
      repeat (140) @(negedge ref_clk);
      fb_on = 1'h0;
    end
    fmask = 24'h00_0000;
    for (int j = 0; j < 3; j++)
      bus(1'h1, RA[j + 2], 8'h00);
    for (int i = 0; i < 24; i++) begin
      c = (i < 10) ? TC[i] : 8'($random(seed));
      d = 3'($random(seed));
      {rx_los, rx_oof, rx_ais} = d;
      bus(1'h1, 8'h16, c);
      rdc(8'h16, c);
      for (int n = 0; n < 200 && !mf; n++)
        @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      e = exp_frame(c, d);
      chk(tx_frame_ctrl.pattern, e.pattern);
      if (e.pattern == dlc_pkg::PAT_NORMAL)
        chk(tx_frame_ctrl.x_value, e.x_value);
    end
    for (int k = 0; k < 4; k++) begin
      m = {2'(k), 2'($random(seed))};
      rx_abort_seen = 1'($random(seed));
      rx_flag_seen = 1'($random(seed));
      msg(m, k == 3);
      chk(rx_buffer_words, (k == 3) ? 8'h29 : 8'h26);
      rdc(8'h15, exp_stat(m, 1'h1));
    end
    @(negedge ref_clk) rx_buffer_drained = 1'h1;
    @(negedge ref_clk) rx_buffer_drained = 1'h0;
    rdc(8'h15, exp_stat(m, 1'h0));
    cbit_mode = 1'h0;
    rdc(8'h15, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
